// ### bench/spdif_rx_host.sv
// axi4-lite host model that drives the register bank
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_host (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // idle bus at time zero
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // one write; each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic bh;
    bh = 1'b0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bh = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic rh;
    rh = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rh = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### bench/test_spdif_rx_ctrl_and_irq_regs.sv
// self-checking bench for the receiver control register bank
`timescale 1ns/1ps
`default_nettype none
`include "spdif_rx_regs_params.svh"
module test_spdif_rx_ctrl_and_irq_regs;
  import spdif_rx_regs_pkg::*;
  logic        clk, rst_n;          // clock and reset
  logic [7:0]  awaddr, araddr;      // bus addresses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;        // bus data
  logic [3:0]  wstrb;               // byte strobes
  logic [1:0]  bresp, rresp;        // responses
  irq_src_s    irq_cond;            // raw interrupt conditions
  logic [7:0]  pins;                // receiver inputs
  logic        pass_o, recv_o, irq_o, irq_oe, deemph;
  logic [5:0]  gain;                // decoded gain
  rx_mode_s    rx_mode;             // decoded mode fields
  buf_ctrl_s   buf_ctrl;            // decoded buffer control
  int          num_errors, n_checks;
  // reset values and writable bits, indices 1D..24
  localparam logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'h40};
  localparam logic [7:0] wm [8] = '{8'h3F, 8'hBF, 8'h77, 8'h00,
                                    8'hBB, 8'hBB, 8'hBB, 8'hC7};
  logic [7:0]  v;                   // scratch register value
  logic [31:0] d;                   // scratch read data
  logic [1:0]  r;                   // scratch response

  spdif_rx_regs i_dut (.clk(clk), .rst_n(rst_n), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready), .irq_cond(irq_cond),
    .digital_audio_input_pins(pins), .passthrough_output_pin(pass_o),
    .receiver_input(recv_o), .right_adc_gain(gain), .rx_mode(rx_mode),
    .deemph_active(deemph), .buf_ctrl(buf_ctrl), .irq_o(irq_o),
    .irq_oe(irq_oe));
  spdif_rx_host i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // register read by index, expecting okay
  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    i_host.rd(i << 2, d, r);
    chk("rdata", e, d);
    chk("rresp", 32'(`RESP_OKAY), 32'(r));
  endtask
  // register write by index
  task automatic wreg(input logic [7:0] i, input logic [7:0] x);
    i_host.wr(i << 2, {24'h0, x}, r);
    chk("bresp", 32'(`RESP_OKAY), 32'(r));
  endtask
  // hold conditions for a few cycles
  task automatic cond(input irq_src_s c);
    @(posedge clk);
    irq_cond <= c;
    repeat (3) @(posedge clk);
  endtask
  // interrupt pin check once settled
  task automatic pin(input logic o, input logic oe);
    @(negedge clk);
    chk("irq_o", 32'(o), 32'(irq_o));
    chk("irq_oe", 32'(oe), 32'(irq_oe));
  endtask
  // verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    irq_cond = '0;
    pins = 8'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(8'h1D + 8'(i), 32'(rst_v[i]));
    pin(1'b0, 1'b1);
    $display("reset values done");
    // all ones written, reserved bits must drop
    for (int i = 0; i < 8; i++) begin
      wreg(8'h1D + 8'(i), 8'hFF);
      rchk(8'h1D + 8'(i), 32'(wm[i]));
    end
    chk("buf_ctrl", 32'h1F, 32'(buf_ctrl));
    i_host.rd(8'h00, d, r);
    chk("unmapped", 32'h0, d);
    chk("unmapped", 32'(`RESP_SLVERR), 32'(r));
    $display("access kinds done");
    // gain codes 0F, 31 and 3B across the range
    foreach (wm[i]) if (i < 3) begin
      v = (i == 0) ? 8'h0F : (i == 1) ? 8'h31 : 8'h3B;
      wreg(8'h1D, v);
      rchk(8'h1D, 32'(v));
      chk("gain", 32'(v[5:0]), 32'(gain));
    end
    // every mode code with nothing pending
    for (int c = 0; c < 4; c++) begin
      v = {c[0], 1'b0, 2'(c), 2'(c), 2'(c)};
      wreg(8'h1E, v);
      chk("rx_mode", 32'({v[7], v[5:0]}), 32'(rx_mode));
      chk("deemph", 32'(c != 0), 32'(deemph));
      pin(c == 1, c != 2);
    end
    // buffer control single fields
    for (int k = 0; k < 4; k++) begin
      v = (k == 3) ? 8'h80 : 8'h01 << k;
      wreg(8'h24, v);
      chk("buf_ctrl", 32'({v[7:6], v[2:0]}), 32'(buf_ctrl));
    end
    $display("control fields done");
    // both input multiplexers, opposite selections
    for (int i = 0; i < 8; i++) begin
      wreg(8'h1F, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
      @(posedge clk);
      pins <= 8'h01 << i;
      @(negedge clk);
      chk("pass", 32'h1, 32'(pass_o));
      chk("recv", 32'h0, 32'(recv_o));
      @(posedge clk);
      pins <= ~(8'h01 << i);
      @(negedge clk);
      chk("pass", 32'h0, 32'(pass_o));
      chk("recv", 32'h1, 32'(recv_o));
    end
    $display("multiplexers done");
    // masked sources never show
    wreg(8'h1E, 8'h00);
    wreg(8'h21, 8'h00);
    wreg(8'h22, 8'h01);
    wreg(8'h23, 8'h02);
    cond('1);
    cond('0);
    rchk(8'h20, 32'h0);
    pin(1'b0, 1'b1);
    // rising for most, level on error, falling on overflow
    wreg(8'h21, 8'hFF);
    cond('1);
    pin(1'b1, 1'b1);
    wreg(8'h1E, 8'h04);
    pin(1'b0, 1'b1);
    wreg(8'h1E, 8'h08);
    pin(1'b0, 1'b1);
    wreg(8'h1E, 8'h00);
    rchk(8'h20, 32'hB9);
    cond('0);
    rchk(8'h20, 32'h03);
    rchk(8'h20, 32'h00);
    pin(1'b0, 1'b1);
    // one source unmasked
    wreg(8'h21, 8'h80);
    cond('1);
    cond('0);
    rchk(8'h20, 32'h80);
    $display("interrupts done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### inc/spdif_rx_regs_params.svh
// constants for the receiver control and interrupt register bank
// How it works
// - right adc gain: six-bit signed dB, ramped
// - phase-align bit locks both serial ports together
// - de-emphasis 01/10/11 only under forced lock; deemph_active is set for any nonzero code, whatever the lock algorithm
// - irq pin: high, low, open-drain low
// - on error hold, zero, or pass sample
// - pass-through select routes input to output pin
// - receiver select routes input to receiver
// - status bit set if event since read
// - reading status clears its bits, except those set again in the same cycle
// - masked status bits always read zero
// - pll unlock raises its status flag
// - qsubcode, channel, user buffer flags separate
// - adc overrange raises overflow flag
// - unmasked receiver error raises error flag
// - mask gates pin and status, resets zero
// - mode bit1 from high reg, bit0 low
// - mode rising, falling, level; 11 reserved
// - pin polarity only from pin style field
// - lock algorithm select, reset value 01
// - buffer select: channel status or user data
// - channel select picks channel a or b
// - access width bit: one or two bytes
`ifndef SPDIF_RX_REGS_PARAMS_SVH
`define SPDIF_RX_REGS_PARAMS_SVH
// byte addresses are four times the printed index
`define IDX_RIGHT_GAIN   8'h1D
`define IDX_RX_MODE      8'h1E
`define IDX_RX_INSEL     8'h1F
`define IDX_IRQ_STATUS   8'h20
`define IDX_IRQ_MASK     8'h21
`define IDX_IRQ_MODE_HI  8'h22
`define IDX_IRQ_MODE_LO  8'h23
`define IDX_BUF_CTRL     8'h24
// writable bit masks per register
`define WMASK_GAIN       8'h3F
`define WMASK_RX_MODE    8'hBF
`define WMASK_INSEL      8'h77
`define WMASK_IRQ        8'hBB
`define WMASK_BUF_CTRL   8'hC7
// reset values
`define RST_GAIN         8'h00
`define RST_RX_MODE      8'h00
`define RST_INSEL        8'h00
`define RST_IRQ          8'h00
`define RST_BUF_CTRL     8'h40
// irq pin styles
`define PIN_ACT_HIGH     2'h0
`define PIN_ACT_LOW      2'h1
`define PIN_OPEN_DRAIN   2'h2
// per-source irq modes
`define MODE_RISE        2'h0
`define MODE_FALL        2'h1
`define MODE_LEVEL       2'h2
// sample substitution codes
`define HOLD_LAST        2'h0
`define HOLD_ZERO        2'h1
`define HOLD_PASS        2'h2
// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ### inc/spdif_rx_regs_pkg.sv
// types shared by the receiver control register bank
package spdif_rx_regs_pkg;
  // decoded receiver mode fields
  typedef struct packed {
    logic       serial_port_phase_align;
    logic [1:0] deemphasis_select;
    logic [1:0] irq_pin_style;
    logic [1:0] hold_mode;
  } rx_mode_s;
  // decoded buffer control fields
  typedef struct packed {
    logic [1:0] receiver_lock_algorithm;
    logic       buffer_content_select;
    logic       buffer_access_width;
    logic       status_channel_select;
  } buf_ctrl_s;
  // interrupt source conditions, in the order of their status bits
  typedef struct packed {
    logic pll_unlock;
    logic qsubcode_change;
    logic chan_status_update;
    logic user_buffer_update;
    logic adc_overrange;
    logic receiver_error;
  } irq_src_s;
  // read channel state
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_e;
endpackage

// ### logic/spdif_rx_regs.sv
// register bank for receiver control and interrupt status
`timescale 1ns/1ps
`default_nettype none
`include "spdif_rx_regs_params.svh"
module spdif_rx_regs #(
  parameter int NUM_INPUTS = 8
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // axi4-lite slave
  input  wire logic [7:0]                   s_awaddr,
  input  wire logic                         s_awvalid,
  output logic                              s_awready,
  input  wire logic [31:0]                  s_wdata,
  input  wire logic [3:0]                   s_wstrb,
  input  wire logic                         s_wvalid,
  output logic                              s_wready,
  output logic [1:0]                        s_bresp,
  output logic                              s_bvalid,
  input  wire logic                         s_bready,
  input  wire logic [7:0]                   s_araddr,
  input  wire logic                         s_arvalid,
  output logic                              s_arready,
  output logic [31:0]                       s_rdata,
  output logic [1:0]                        s_rresp,
  output logic                              s_rvalid,
  input  wire logic                         s_rready,
  // raw interrupt conditions from the receiver and adc
  input  wire spdif_rx_regs_pkg::irq_src_s  irq_cond,
  // receiver inputs and muxed outputs
  input  wire logic [NUM_INPUTS-1:0]        digital_audio_input_pins,
  output logic                              passthrough_output_pin,
  output logic                              receiver_input,
  // decoded controls
  output logic [5:0]                        right_adc_gain,
  output spdif_rx_regs_pkg::rx_mode_s       rx_mode,
  output logic                              deemph_active,
  output spdif_rx_regs_pkg::buf_ctrl_s      buf_ctrl,
  // interrupt pin as two signals
  output logic                              irq_o,
  output logic                              irq_oe
);
  import spdif_rx_regs_pkg::*;

  localparam int SELW = $clog2(NUM_INPUTS);

  // stored registers
  logic [7:0] gain_q;
  logic [7:0] rx_mode_q;
  logic [7:0] insel_q;
  logic [7:0] mask_q;
  logic [7:0] mode_hi_q;
  logic [7:0] mode_lo_q;
  logic [7:0] buf_ctrl_q;
  logic [7:0] status_q;
  logic [7:0] cond_prev_q;
  logic [7:0] cond_now;
  logic [7:0] event_hit;
  logic [7:0] mask_d;      // mask as it will stand after this edge
  logic [7:0] event_keep;  // events that survive the next mask

  // write channel capture
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;
  logic       wr_fire;
  logic       wr_ok;
  logic [7:0] wr_idx;

  // read channel
  rd_state_e  rd_state_q;
  logic       rd_fire;
  logic       status_read;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic       rd_ok;

  // conditions packed into status bit positions
  always_comb begin
    cond_now    = 8'h00;
    cond_now[7] = irq_cond.pll_unlock;
    cond_now[5] = irq_cond.qsubcode_change;
    cond_now[4] = irq_cond.chan_status_update;
    cond_now[3] = irq_cond.user_buffer_update;
    cond_now[1] = irq_cond.adc_overrange;
    cond_now[0] = irq_cond.receiver_error;
  end

  // per-source event detect by two-bit mode
  always_comb begin
    event_hit = 8'h00;
    for (int i = 0; i < 8; i++) begin
      case ({mode_hi_q[i], mode_lo_q[i]})
        `MODE_RISE:  event_hit[i] = cond_now[i] & ~cond_prev_q[i];
        `MODE_FALL:  event_hit[i] = ~cond_now[i] & cond_prev_q[i];
        `MODE_LEVEL: event_hit[i] = cond_now[i];
        default:     event_hit[i] = 1'b0;          // reserved mode
      endcase
    end
    event_hit = event_hit & mask_q & `WMASK_IRQ;
  end

  // previous condition for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_prev_q <= 8'h00;
    end else begin
      cond_prev_q <= cond_now;
    end
  end

  // next mask, so a narrowed mask drops pending bits at once
  always_comb begin
    mask_d = mask_q;
    if (wr_fire && wr_ok && w_lane0_q && (wr_idx == `IDX_IRQ_MASK)) begin
      mask_d = w_data_q & `WMASK_IRQ;
    end
    event_keep = event_hit & mask_d;
  end

  // sticky status: set wins over read clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= `RST_IRQ;
    end else begin
      status_q <= ((status_read ? 8'h00 : status_q)
                   | event_keep) & mask_d;
    end
  end

  // write address and data may arrive in either order
  assign s_awready = !aw_held_q;
  assign s_wready  = !w_held_q;
  assign wr_fire   = aw_held_q && w_held_q && !s_bvalid;
  assign wr_idx    = {2'b00, aw_addr_q[7:2]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_awvalid && s_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_held_q  <= 1'b1;
      w_data_q  <= s_wdata[7:0];
      w_lane0_q <= s_wstrb[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // decode of addresses that answer okay to a write, read-only status included
  always_comb begin
    case (wr_idx)
      `IDX_RIGHT_GAIN, `IDX_RX_MODE, `IDX_RX_INSEL, `IDX_IRQ_STATUS,
      `IDX_IRQ_MASK, `IDX_IRQ_MODE_HI, `IDX_IRQ_MODE_LO,
      `IDX_BUF_CTRL: wr_ok = (aw_addr_q[1:0] == 2'b00);
      default:       wr_ok = 1'b0;
    endcase
  end

  // register writes, reserved bits dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_q     <= `RST_GAIN;
      rx_mode_q  <= `RST_RX_MODE;
      insel_q    <= `RST_INSEL;
      mask_q     <= `RST_IRQ;
      mode_hi_q  <= `RST_IRQ;
      mode_lo_q  <= `RST_IRQ;
      buf_ctrl_q <= `RST_BUF_CTRL;
    end else if (wr_fire && wr_ok && w_lane0_q) begin
      case (wr_idx)
        `IDX_RIGHT_GAIN:  gain_q     <= w_data_q & `WMASK_GAIN;
        `IDX_RX_MODE:     rx_mode_q  <= w_data_q & `WMASK_RX_MODE;
        `IDX_RX_INSEL:    insel_q    <= w_data_q & `WMASK_INSEL;
        `IDX_IRQ_MASK:    mask_q     <= mask_d;
        `IDX_IRQ_MODE_HI: mode_hi_q  <= w_data_q & `WMASK_IRQ;
        `IDX_IRQ_MODE_LO: mode_lo_q  <= w_data_q & `WMASK_IRQ;
        `IDX_BUF_CTRL:    buf_ctrl_q <= w_data_q & `WMASK_BUF_CTRL;
        default: begin
          // status is read-only
        end
      endcase
    end
  end

  // write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // read path
  assign s_arready   = (rd_state_q == RD_IDLE);
  assign rd_fire     = s_arvalid && s_arready;
  assign rd_idx      = {2'b00, s_araddr[7:2]};
  assign status_read = rd_fire && rd_ok && (rd_idx == `IDX_IRQ_STATUS);

  // read mux
  always_comb begin
    rd_ok  = (s_araddr[1:0] == 2'b00);
    rd_val = 8'h00;
    case (rd_idx)
      `IDX_RIGHT_GAIN:  rd_val = gain_q;
      `IDX_RX_MODE:     rd_val = rx_mode_q;
      `IDX_RX_INSEL:    rd_val = insel_q;
      `IDX_IRQ_STATUS:  rd_val = status_q & mask_q;
      `IDX_IRQ_MASK:    rd_val = mask_q;
      `IDX_IRQ_MODE_HI: rd_val = mode_hi_q;
      `IDX_IRQ_MODE_LO: rd_val = mode_lo_q;
      `IDX_BUF_CTRL:    rd_val = buf_ctrl_q;
      default:          rd_ok  = 1'b0;
    endcase
  end

  // read state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_state_q <= RD_IDLE;
      s_rdata    <= 32'h0000_0000;
      s_rresp    <= `RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (rd_fire) begin
            rd_state_q <= RD_RESP;
            s_rdata    <= {24'h00_0000, rd_ok ? rd_val : 8'h00};
            s_rresp    <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        RD_RESP: begin
          if (s_rready) begin
            rd_state_q <= RD_IDLE;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end
  assign s_rvalid = (rd_state_q == RD_RESP);

  // decoded control outputs
  assign right_adc_gain = gain_q[5:0];
  assign rx_mode.serial_port_phase_align = rx_mode_q[7];
  assign rx_mode.deemphasis_select = rx_mode_q[5:4];
  assign rx_mode.irq_pin_style = rx_mode_q[3:2];
  assign rx_mode.hold_mode = rx_mode_q[1:0];
  assign deemph_active = (rx_mode_q[5:4] != 2'b00);
  assign buf_ctrl.receiver_lock_algorithm = buf_ctrl_q[7:6];
  assign buf_ctrl.buffer_content_select = buf_ctrl_q[2];
  assign buf_ctrl.buffer_access_width = buf_ctrl_q[1];
  assign buf_ctrl.status_channel_select = buf_ctrl_q[0];

  // input multiplexers straight from the pins
  assign passthrough_output_pin =
    digital_audio_input_pins[insel_q[4 +: SELW]];
  assign receiver_input =
    digital_audio_input_pins[insel_q[0 +: SELW]];

  // interrupt pin from pending status and pin style only
  logic irq_pending;
  assign irq_pending = |(status_q & mask_q);
  always_comb begin
    irq_o  = 1'b0;
    irq_oe = 1'b1;
    case (rx_mode_q[3:2])
      `PIN_ACT_HIGH:   irq_o = irq_pending;
      `PIN_ACT_LOW:    irq_o = !irq_pending;
      `PIN_OPEN_DRAIN: irq_oe = irq_pending;
      default:         irq_o = irq_pending;
    endcase
  end

  // assertions
  property p_status_clear;
    @(posedge clk) disable iff (!rst_n)
      (status_read && (event_hit == 8'h00)) |=> (status_q == 8'h00);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status not cleared by read");

  property p_event_sets;
    @(posedge clk) disable iff (!rst_n)
      (event_keep != 8'h00) |=> ((status_q & $past(event_keep)) != 8'h00);
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event lost");

  property p_masked_zero;
    @(posedge clk) disable iff (!rst_n)
      (status_q & ~mask_q) == 8'h00;
  endproperty
  a_masked_zero: assert property (p_masked_zero)
    else $error("masked status bit set");

  property p_pin_high;
    @(posedge clk) disable iff (!rst_n)
      (rx_mode_q[3:2] == `PIN_ACT_HIGH) |-> (irq_o == irq_pending && irq_oe);
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("irq pin style wrong");

  property p_od;
    @(posedge clk) disable iff (!rst_n)
      (rx_mode_q[3:2] == `PIN_OPEN_DRAIN) |-> (!irq_o && irq_oe == irq_pending);
  endproperty
  a_od: assert property (p_od)
    else $error("open drain pin wrong");

  property p_rise;
    @(posedge clk) disable iff (!rst_n)
      (mask_q[7] && mask_d[7] && !mode_hi_q[7] && !mode_lo_q[7]
       && !cond_prev_q[7] && cond_now[7]) |=> status_q[7];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising event missed");

  property p_unmasked_none;
    @(posedge clk) disable iff (!rst_n)
      (mask_q == 8'h00) |-> (event_hit == 8'h00);
  endproperty
  a_unmasked_none: assert property (p_unmasked_none)
    else $error("masked source reached status");

  property p_txmux;
    @(posedge clk) disable iff (!rst_n)
      passthrough_output_pin == digital_audio_input_pins[insel_q[6:4]];
  endproperty
  a_txmux: assert property (p_txmux)
    else $error("pass-through mux wrong");

  sequence s_rd_req;
    rd_fire;
  endsequence
  property p_rd_answer;
    @(posedge clk) disable iff (!rst_n)
      s_rd_req |=> s_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");

  property p_pin_low;
    @(posedge clk) disable iff (!rst_n)
      (rx_mode_q[3:2] == `PIN_ACT_LOW)
        |-> (irq_o == !irq_pending && irq_oe);
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("active low pin wrong");

  property p_rxmux;
    @(posedge clk) disable iff (!rst_n)
      receiver_input == digital_audio_input_pins[insel_q[2:0]];
  endproperty
  a_rxmux: assert property (p_rxmux)
    else $error("receiver mux wrong");

  property p_read_masked;
    @(posedge clk) disable iff (!rst_n)
      status_read |=> ((s_rdata[7:0] & ~$past(mask_q)) == 8'h00);
  endproperty
  a_read_masked: assert property (p_read_masked)
    else $error("masked status bit read back");
endmodule
`default_nettype wire
